/* hdl/swbwd_pkg.sv */
// Constants and types shared by the sync word and bus width detector.
package swbwd_pkg;

  // ----------------------------------------------------------------
  // Synchronization pattern as seen on the data pins
  // ----------------------------------------------------------------
  localparam logic [7:0] SYNC_B3 = 8'hAA;
  localparam logic [7:0] SYNC_B2 = 8'h99;
  localparam logic [7:0] SYNC_B1 = 8'h55;
  localparam logic [7:0] SYNC_B0 = 8'h66;
  localparam logic [7:0] PAD_BYTE = 8'hFF;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int BYTE_W = 8;
  localparam int WORD_W = 32;
  localparam int FIFO_DEPTH = 16;

  // ----------------------------------------------------------------
  // Detector states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_SEARCH = 7'h01,
    ST_X8_B3 = 7'h02,
    ST_X8_B2 = 7'h04,
    ST_X8_B1 = 7'h08,
    ST_X16_HI = 7'h10,
    ST_SYNC8 = 7'h20,
    ST_SYNC16 = 7'h40
  } swbwd_state_t;

endpackage

/* hdl/swbwd_fifo_if.sv */
// Carrier between the detector and its word FIFO.
`timescale 1ns/1ps
`default_nettype none
interface swbwd_fifo_if #(
  parameter int WIDTH = 32
);
  logic in_valid;
  logic in_ready;
  logic [WIDTH-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [WIDTH-1:0] out_data;

  modport src (output in_valid, output in_data, input in_ready,
               input out_valid, input out_data, output out_ready);
  modport fifo (input in_valid, input in_data, output in_ready,
                output out_valid, output out_data, input out_ready);
endinterface
`default_nettype wire

/* hdl/swbwd_fifo.sv */
// Word FIFO with registered ready and a registered output stage.
`timescale 1ns/1ps
`default_nettype none
module swbwd_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Both sides
  swbwd_fifo_if.fifo f
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  // A push needs room; a pop refills the output stage when it is free.
  assign push = f.in_valid && f.in_ready;
  assign pop = (count != '0) && (!f.out_valid || f.out_ready);
  assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);

  // Storage array write.
  always_ff @(posedge clk_in)
  begin
    if (push)
      mem[wr_ptr] <= f.in_data;
  end

  // Pointers, fill level, registered ready and output stage.
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      f.in_ready <= 1'b0;
      f.out_valid <= 1'b0;
      f.out_data <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + AW'(1);
      if (pop)
        rd_ptr <= rd_ptr + AW'(1);
      count <= next_count;
      f.in_ready <= next_count < (AW+1)'(DEPTH); // Honest full.
      if (pop)
      begin
        f.out_valid <= 1'b1;
        f.out_data <= mem[rd_ptr];
      end
      else if (f.out_ready)
        f.out_valid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* hdl/swbwd_detect.sv */
// Sync word finder, bus width detector and word assembler.
`timescale 1ns/1ps
`default_nettype none
module swbwd_detect #(
  parameter int DEPTH = swbwd_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Parallel configuration pins, low lane in bits 7:0
  input wire logic [15:0] pin_data_in,
  input wire logic pin_valid_in,
  output logic pin_ready_out,
  // Assembled configuration words
  output logic [31:0] word_data_out,
  output logic word_valid_out,
  input wire logic word_ready_in,
  // Status
  output logic synced_out,
  output logic width_x16_out
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  swbwd_pkg::swbwd_state_t state;
  swbwd_pkg::swbwd_state_t next_state;
  swbwd_pkg::swbwd_state_t restart_state;
  swbwd_fifo_if #(.WIDTH(swbwd_pkg::WORD_W)) fq ();
  logic [7:0] lo_lane;
  logic [7:0] hi_lane;
  logic [7:0] lo_stream;
  logic [7:0] hi_stream;
  logic take;
  logic lo_b3;
  logic lo_b2;
  logic lo_b1;
  logic lo_b0;
  logic hi_b3;
  logic hi_b1;
  logic [31:0] shreg;
  logic [31:0] next_shreg;
  logic [1:0] fill;
  logic [1:0] last_fill;
  logic word_done;
  logic pend;
  logic next_pend;

  // Reverse the bits of a byte: pin zero carries the stream MSB.
  function automatic logic [7:0] unswap(input logic [7:0] b);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++)
      r[i] = b[7-i];
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Lane decode
  // ----------------------------------------------------------------
  // Patterns are matched as seen on the pins.
  assign lo_lane = pin_data_in[7:0];
  assign hi_lane = pin_data_in[15:8];
  assign lo_b3 = lo_lane == swbwd_pkg::SYNC_B3;
  assign lo_b2 = lo_lane == swbwd_pkg::SYNC_B2;
  assign lo_b1 = lo_lane == swbwd_pkg::SYNC_B1;
  assign lo_b0 = lo_lane == swbwd_pkg::SYNC_B0;
  assign hi_b3 = hi_lane == swbwd_pkg::SYNC_B3;
  assign hi_b1 = hi_lane == swbwd_pkg::SYNC_B1;

  // Stream order bytes for the assembled words.
  assign lo_stream = unswap(lo_lane);
  assign hi_stream = unswap(hi_lane);

  // A pin transfer is taken when valid meets ready.
  assign take = pin_valid_in && pin_ready_out;

  // ----------------------------------------------------------------
  // Width detection
  // ----------------------------------------------------------------
  // Where a search starts from the present byte; pads and other bytes
  // leave the detector searching and are dropped.
  assign restart_state = lo_b3 ? swbwd_pkg::ST_X8_B3 :
                         (lo_b2 && hi_b3) ? swbwd_pkg::ST_X16_HI :
                         swbwd_pkg::ST_SEARCH;

  // Next detector state, moved only by taken transfers.
  always_comb
  begin
    next_state = state;
    if (take)
    begin
      unique case (state)
        swbwd_pkg::ST_SEARCH:
          next_state = restart_state;
        // With 0xAA on the upper lane a low 0x99 is the x16 start instead.
        swbwd_pkg::ST_X8_B3:
          next_state = (lo_b2 && !hi_b3) ? swbwd_pkg::ST_X8_B2 : restart_state;
        swbwd_pkg::ST_X8_B2:
          next_state = lo_b1 ? swbwd_pkg::ST_X8_B1 : restart_state;
        swbwd_pkg::ST_X8_B1:
          next_state = lo_b0 ? swbwd_pkg::ST_SYNC8 : restart_state;
        swbwd_pkg::ST_X16_HI:
          next_state = (lo_b0 && hi_b1) ? swbwd_pkg::ST_SYNC16 : restart_state;
        swbwd_pkg::ST_SYNC8,
        swbwd_pkg::ST_SYNC16:
          next_state = state; // Width is locked until reset.
        default:
          next_state = swbwd_pkg::ST_SEARCH;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Word assembly
  // ----------------------------------------------------------------
  // x8 fills four bytes, x16 two halves; first arrival is bits 31:24.
  assign last_fill = (state == swbwd_pkg::ST_SYNC16) ? 2'h1 : 2'h3;
  assign word_done = take && synced_out && (fill == last_fill);
  assign next_shreg = (state == swbwd_pkg::ST_SYNC16) ?
                      {shreg[15:0], hi_stream, lo_stream} :
                      {shreg[23:0], lo_stream};

  // A finished word waits here until the FIFO accepts it.
  assign next_pend = word_done || (pend && !fq.in_ready);
  assign fq.in_valid = pend;
  assign fq.in_data = shreg;
  assign fq.out_ready = word_ready_in;

  // Detector state and status flags.
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      state <= swbwd_pkg::ST_SEARCH;
      synced_out <= 1'b0;
      width_x16_out <= 1'b0;
    end
    else
    begin
      state <= next_state;
      synced_out <= next_state[5] || next_state[6];
      width_x16_out <= next_state == swbwd_pkg::ST_SYNC16;
    end
  end

  // Assembly register and transfer count; only data after sync enters.
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      shreg <= '0;
      fill <= '0;
    end
    else if (take && synced_out)
    begin
      shreg <= next_shreg;
      fill <= word_done ? 2'h0 : fill + 2'h1;
    end
  end

  // Pending word and pin back-pressure.
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      pend <= 1'b0;
      pin_ready_out <= 1'b0;
    end
    else
    begin
      pend <= next_pend;
      pin_ready_out <= !next_pend; // Stalls the pins while a word waits.
    end
  end

  // ----------------------------------------------------------------
  // Word FIFO
  // ----------------------------------------------------------------
  swbwd_fifo #(
    .WIDTH(swbwd_pkg::WORD_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .f(fq.fifo)
  );

  // Outputs come from the FIFO's output stage flip-flops.
  assign word_valid_out = fq.out_valid;
  assign word_data_out = fq.out_data;

endmodule
`default_nettype wire

/* dv/swbwd_detect_monitor.sv */
// Checker of the detector's port behaviour.
`timescale 1ns/1ps
`default_nettype none
module swbwd_detect_monitor (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Pin side
  input wire logic [15:0] pin_data_in,
  input wire logic pin_valid_in,
  input wire logic pin_ready_out,
  // Word side and status
  input wire logic [31:0] word_data_out,
  input wire logic word_valid_out,
  input wire logic word_ready_in,
  input wire logic synced_out,
  input wire logic width_x16_out
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // A transfer is taken when both sides agree.
  wire t = pin_valid_in && pin_ready_out;
  wire [7:0] lo = pin_data_in[7:0];
  AST_NO_WORD_EARLY: assert property (!synced_out |-> !word_valid_out)
    else $error("word offered before sync");
  AST_NO_WIDTH_EARLY: assert property (!synced_out |-> !width_x16_out)
    else $error("width set before sync");
  AST_WIDTH_LOCK: assert property (synced_out |=> synced_out && $stable(width_x16_out))
    else $error("width changed after sync");
  AST_SYNC_CAUSE: assert property ($rose(synced_out) |-> $past(t) && $past(lo) == 8'h66)
    else $error("sync without closing byte");
  AST_X8_FOUND: assert property (t && lo == 8'hAA && !synced_out ##1
    t && lo == 8'h99 && pin_data_in[15:8] != 8'hAA ##1 t && lo == 8'h55 ##1
    t && lo == 8'h66 |=> synced_out && !width_x16_out)
    else $error("byte wide sync missed");
  AST_X16_FOUND: assert property (t && pin_data_in == 16'hAA99 && !synced_out ##1
    t && pin_data_in == 16'h5566 |=> synced_out && width_x16_out)
    else $error("halfword wide sync missed");
  AST_X16_PAIR: assert property (synced_out && width_x16_out && t ##1 t |=> !pin_ready_out)
    else $error("ready kept after two halves");
  AST_BREAK: assert property (t && lo == 8'hAA && !synced_out ##1
    t && lo != 8'h99 && lo != 8'hAA ##1 t && lo == 8'h55 ##1 t && lo == 8'h66
    |=> !synced_out)
    else $error("broken match still synced");
  COV_X8: cover property ($rose(synced_out) && !width_x16_out);
  COV_X16: cover property ($rose(synced_out) && width_x16_out);
  COV_FULL: cover property (synced_out && !pin_ready_out [*8]);
endmodule
bind swbwd_detect swbwd_detect_monitor mon_u (.clk_in(clk_in), .resetn_in(resetn_in),
  .pin_data_in(pin_data_in), .pin_valid_in(pin_valid_in), .pin_ready_out(pin_ready_out),
  .word_data_out(word_data_out), .word_valid_out(word_valid_out),
  .word_ready_in(word_ready_in), .synced_out(synced_out), .width_x16_out(width_x16_out));
`default_nettype wire

/* dv/swbwd_host_model.sv */
// Configuration host that presents queued transfers on the pins.
`timescale 1ns/1ps
`default_nettype none
module swbwd_host_model (
  // Clock and handshake
  input wire logic clk_in,
  input wire logic ready_in,
  // Pins
  output logic [15:0] data_out,
  output logic valid_out
);
  logic [15:0] q[$];
  // Stream bytes go out mirrored, stream MSB on pin zero.
  task automatic dat(input logic [7:0] hi, input logic [7:0] lo);
    q.push_back({{<<{hi}}, {<<{lo}}});
  endtask
  // Pads, then the sync word in two halves as seen at the pins.
  task automatic sync16();
    q.push_back(16'hFFFF);
    q.push_back(16'hFFFF);
    q.push_back(16'hAA99);
    q.push_back(16'h5566);
  endtask
  initial
  begin
    valid_out = 1'b0;
    data_out = 16'h0000;
  end
  // Retire a transfer at the edge that takes it.
  always @(posedge clk_in)
    if (valid_out && ready_in && q.size() != 0)
      void'(q.pop_front());
  // Present the next transfer; idle pins toggle so stale data never looks held.
  always @(negedge clk_in)
  begin
    valid_out = (q.size() != 0);
    data_out = valid_out ? q[0] : ~data_out;
  end
endmodule
`default_nettype wire

/* dv/swbwd_detect_tb.sv */
// Self-checking testbench of the sync word and bus width detector.
`timescale 1ns/1ps
`default_nettype none
module swbwd_detect_tb;
  logic clk_in = 1'b0, resetn_in = 1'b0, word_ready_in = 1'b0;
  logic [15:0] pin_data_in;
  logic pin_valid_in, pin_ready_out, word_valid_out, synced_out, width_x16_out;
  logic [31:0] word_data_out, w;
  logic [31:0] exp_q[$];
  int failures = 0, num_checks = 0, rcvd = 0;
  always #4 clk_in = ~clk_in;
  swbwd_detect dut_u (.clk_in(clk_in), .resetn_in(resetn_in), .pin_data_in(pin_data_in),
    .pin_valid_in(pin_valid_in), .pin_ready_out(pin_ready_out),
    .word_data_out(word_data_out), .word_valid_out(word_valid_out),
    .word_ready_in(word_ready_in), .synced_out(synced_out), .width_x16_out(width_x16_out));
  swbwd_host_model host_u (.clk_in(clk_in), .ready_in(pin_ready_out),
    .data_out(pin_data_in), .valid_out(pin_valid_in));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Every word leaving the block is compared with the expected stream.
  always @(posedge clk_in)
    if (word_valid_out === 1'b1 && word_ready_in)
    begin
      rcvd++;
      check(word_data_out, exp_q.size() ? exp_q.pop_front() : 32'hDEADBEEF);
    end
  task automatic do_reset();
    resetn_in = 1'b0;
    repeat (16) @(negedge clk_in);
    resetn_in = 1'b1;
    rcvd = 0;
  endtask
  task automatic wait_host();
    for (int i = 0; i < 400 && host_u.q.size() != 0; i++)
      @(negedge clk_in);
    repeat (6) @(negedge clk_in);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  // Byte wide: a pad, a broken start, then the sync word and one word.
  task automatic test_x8();
    logic [7:0] s[10] = '{8'hFF, 8'hAA, 8'h12, 8'h55, 8'h66, 8'hAA, 8'h99, 8'h55, 8'h66, 8'hFF};
    do_reset();
    word_ready_in = 1'b1;
    for (int i = 0; i < 9; i++)
      host_u.q.push_back({8'h3C, s[i]});
    exp_q.push_back(32'h12345678);
    host_u.dat(8'hC3, 8'h12);
    host_u.dat(8'hC3, 8'h34);
    host_u.dat(8'hC3, 8'h56);
    host_u.dat(8'hC3, 8'h78);
    wait_host();
    check({30'h0, synced_out, width_x16_out}, 32'h2);
    check(32'(rcvd), 32'h1);
    $display("test x8 done");
  endtask
  // Halfword wide: fill the buffer until it refuses, then drain with stalls.
  task automatic test_x16();
    do_reset();
    word_ready_in = 1'b0;
    host_u.sync16();
    for (int k = 0; k < 20; k++)
    begin
      w = 32'h11223344 ^ k;
      exp_q.push_back(w);
      host_u.dat(w[31:24], w[23:16]);
      host_u.dat(w[15:8], w[7:0]);
    end
    repeat (80) @(negedge clk_in);
    check({30'h0, synced_out, width_x16_out}, 32'h3);
    check({31'h0, pin_ready_out}, 32'h0);
    check(32'(rcvd), 32'h0);
    for (int i = 0; i < 400 && rcvd < 20; i++)
      @(negedge clk_in) word_ready_in = ~word_ready_in;
    word_ready_in = 1'b1;
    wait_host();
    check(32'(rcvd), 32'h14);
    $display("test x16 done");
  endtask
  initial
  begin
    test_x8();
    test_x16();
    stop_test();
  end
  initial
  begin
    repeat (3000) @(posedge clk_in);
    failures++;
    stop_test();
  end
endmodule
`default_nettype wire
